// ==== core/qpsc_pkg.sv ====
// Overview of operation
// - write-protect low blocks every nonvolatile data register save
// - serial input bits are taken on the rising serial clock edge
// - serial output has an enable so it can share the input wire
// - each array enables at most one of its tap switches at a time
// - each 8-bit wiper register decodes one-hot onto 256 tap enables
// - four independent wiper registers, one per potentiometer
// - write-wiper instruction loads a wiper register from a host byte
// - single or global transfer loads wipers from a chosen data register
// - step instruction moves a wiper one position per rising serial clock, holding at either end
// - at power-up each wiper loads from its pot's data register zero
// - four 8-bit nonvolatile data registers per pot, host readable and writable
// - a data register change completes within at most 10 ms
// - save starts only on select rising after a complete write sequence
// - write-busy flag shows a save in progress, read by read-status
// - first byte after select falls is the identification byte
// - upper identification nibble must match the device type code
// - low two identification bits must match the address pins, else stop
// - read data leaves on the falling serial clock edge
// - pause and resume only with clock low; sequence state is kept
// - all activity ignored until select has fallen once after power-up
// - second byte: instruction nibble, register select, pot select
package qpsc_pkg;
  // ==========================================================
  // geometry
  localparam int unsigned N_POTS = 4;
  localparam int unsigned N_REGS = 4;
  localparam int unsigned WIPER_W = 8;
  localparam int unsigned TAPS = 256;
  localparam logic [7:0] WIPER_MIN = 8'h00;
  localparam logic [7:0] WIPER_MAX = 8'hff;
  localparam logic [7:0] NV_INIT = 8'h00;
  localparam logic [255:0] TAP_RESET = 256'h1;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  // ==========================================================
  // identification and instruction byte fields
  localparam logic [3:0] TYPE_CODE = 4'h9; // arbitrary value
  localparam int unsigned HI_MSB = 7;
  localparam int unsigned HI_LSB = 4;
  localparam int unsigned REG_MSB = 3;
  localparam int unsigned REG_LSB = 2;
  localparam int unsigned POT_MSB = 1;
  localparam int unsigned POT_LSB = 0;
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'ha;
  localparam logic [3:0] OP_RD_NV = 4'hb;
  localparam logic [3:0] OP_WR_NV = 4'hc;
  localparam logic [3:0] OP_NV_TO_WIPER = 4'hd;
  localparam logic [3:0] OP_WIPER_TO_NV = 4'he;
  localparam logic [3:0] OP_G_NV_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_G_WIPER_TO_NV = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_STATUS = 4'h5;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned NV_WRITE_MS = 10;
  // longest time, so rounded down
  localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {ST_ID, ST_INSTR, ST_DATA, ST_READ, ST_STEP, ST_DONE,
                            ST_SKIP} qpsc_state_t;

  function automatic logic [3:0] hi_of(input logic [7:0] b);
    return b[HI_MSB:HI_LSB];
  endfunction : hi_of

  function automatic logic [1:0] reg_of(input logic [7:0] b);
    return b[REG_MSB:REG_LSB];
  endfunction : reg_of

  function automatic logic [1:0] pot_of(input logic [7:0] b);
    return b[POT_MSB:POT_LSB];
  endfunction : pot_of

  function automatic logic [255:0] onehot(input logic [7:0] v);
    logic [255:0] r;
    r = '0;
    r[v] = 1'b1;
    return r;
  endfunction : onehot

  function automatic logic [7:0] step(input logic [7:0] v, input logic up);
    logic [7:0] r;
    r = v;
    if (up && v != WIPER_MAX) r = 8'(v + 8'h01);
    if (!up && v != WIPER_MIN) r = 8'(v - 8'h01);
    return r;
  endfunction : step
endpackage : qpsc_pkg

// ==== core/qpsc_if.sv ====
// ==========================================================
// serial front end towards the command core
interface qpsc_link_if;
  logic sck_rise;
  logic sck_fall;
  logic si;
  logic cs_rise;
  logic byte_valid;
  logic [7:0] byte_data;
  logic wp_n;
  logic [1:0] addr;
  modport rx (output sck_rise, sck_fall, si, cs_rise, byte_valid, byte_data, wp_n, addr);
  modport core (input sck_rise, sck_fall, si, cs_rise, byte_valid, byte_data, wp_n, addr);
endinterface : qpsc_link_if

// ==========================================================
// data register store towards the command core
interface qpsc_nv_if;
  logic wr_req;
  logic wr_global;
  logic [1:0] wr_pot;
  logic [1:0] wr_reg;
  logic [7:0] wr_data;
  logic [31:0] wr_wipers;
  logic [1:0] rd_pot;
  logic [1:0] rd_reg;
  logic [7:0] rd_data;
  logic [31:0] rd_col;
  logic busy;
  modport store (input wr_req, wr_global, wr_pot, wr_reg, wr_data, wr_wipers, rd_pot,
                 rd_reg, output rd_data, rd_col, busy);
  modport core (output wr_req, wr_global, wr_pot, wr_reg, wr_data, wr_wipers, rd_pot,
                rd_reg, input rd_data, rd_col, busy);
endinterface : qpsc_nv_if

// ==== core/qpsc_serial_rx.sv ====
module qpsc_serial_rx (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // pins
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_cs_n,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic [1:0] i_addr,
  // towards the core
  qpsc_link_if.rx lnk
);
  // ==========================================================
  // synchronisers, order {addr, wp, hold, cs, si, sck}
  logic [6:0] meta_q;
  logic [6:0] sync_q;
  logic sck_prev_q;
  logic cs_prev_q;
  logic armed_q;
  logic [2:0] cnt_q;
  logic [7:0] shift_q;
  logic valid_q;
  wire sck_s = sync_q[0];
  wire si_s = sync_q[1];
  wire cs_s = sync_q[2];
  wire hold_s = sync_q[3];
  wire cs_fall_w = cs_prev_q && !cs_s;
  wire active_w = armed_q && !cs_s;
  // edges are frozen while paused; host only toggles pause with clock low
  wire rise_w = active_w && hold_s && sck_s && !sck_prev_q;
  wire fall_w = active_w && hold_s && !sck_s && sck_prev_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end else begin
      meta_q <= {i_addr, i_wp_n, i_hold_n, i_cs_n, i_si, i_sck};
      sync_q <= meta_q;
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_s;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      armed_q <= 1'b0;
    end else if (cs_fall_w) begin
      armed_q <= 1'b1;
    end
  end

  // bit count restarts whenever select is high, so a new frame opens on an id byte
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      shift_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (!active_w) begin
        cnt_q <= '0;
      end else if (rise_w) begin
        shift_q <= {shift_q[6:0], si_s};
        cnt_q <= 3'(cnt_q + 3'h1);
        valid_q <= (cnt_q == 3'h7);
      end
    end
  end

  assign lnk.sck_rise = rise_w;
  assign lnk.sck_fall = fall_w;
  assign lnk.si = si_s;
  assign lnk.cs_rise = !cs_prev_q && cs_s && armed_q;
  assign lnk.byte_valid = valid_q;
  assign lnk.byte_data = shift_q;
  assign lnk.wp_n = sync_q[4];
  assign lnk.addr = sync_q[6:5];

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_byte_after_rise: assert property (valid_q |-> $past(rise_w))
    else $error("byte completed without a rising clock edge");
  a_ignore_before_arm: assert property (!armed_q |-> !rise_w && !valid_q)
    else $error("activity accepted before first select fall");
endmodule : qpsc_serial_rx

// ==== core/qpsc_nv_store.sv ====
module qpsc_nv_store #(
  parameter int unsigned NV_CYCLES = qpsc_pkg::NV_WRITE_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // towards the core
  qpsc_nv_if.store nv
);
  localparam int unsigned CW = $clog2(NV_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(NV_CYCLES);
  if (NV_CYCLES < 1) begin : g_chk
    $error("NV_CYCLES must be at least one");
  end
  // a flop array stands in for the cells; reset gives the blank value
  logic [7:0] mem_q [qpsc_pkg::N_POTS][qpsc_pkg::N_REGS];
  logic [CW-1:0] cnt_q;
  wire start_w = nv.wr_req && cnt_q == '0;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int p = 0; p < qpsc_pkg::N_POTS; p++) begin
        for (int r = 0; r < qpsc_pkg::N_REGS; r++) begin
          mem_q[p][r] <= qpsc_pkg::NV_INIT;
        end
      end
    end else if (start_w) begin
      for (int p = 0; p < qpsc_pkg::N_POTS; p++) begin
        if (nv.wr_global) mem_q[p][nv.wr_reg] <= nv.wr_wipers[p*8 +: 8];
      end
      if (!nv.wr_global) mem_q[nv.wr_pot][nv.wr_reg] <= nv.wr_data;
    end
  end

  // a request while busy is dropped: the cells cannot take a second save
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) cnt_q <= '0;
    else if (start_w) cnt_q <= LOAD;
    else if (cnt_q != '0) cnt_q <= CW'(cnt_q - 1'b1);
  end

  assign nv.busy = cnt_q != '0;
  assign nv.rd_data = mem_q[nv.rd_pot][nv.rd_reg];
  for (genvar p = 0; p < qpsc_pkg::N_POTS; p++) begin : g_col
    assign nv.rd_col[p*8 +: 8] = mem_q[p][nv.rd_reg];
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_busy_bound: assert property (cnt_q <= LOAD)
    else $error("save time counter above its limit");
  a_busy_ends: assert property (cnt_q == CW'(1) |=> !nv.busy)
    else $error("busy flag outlived the save time");
endmodule : qpsc_nv_store

// ==== core/qpsc_top.sv ====
module qpsc_top #(
  parameter int unsigned NV_WRITE_CYCLES = qpsc_pkg::NV_WRITE_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // serial port
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_cs_n,
  input wire logic i_hold_n,
  output logic o_so,
  output logic o_so_oe,
  // straps
  input wire logic i_wp_n,
  input wire logic [1:0] i_chip_address_pins,
  // tap switch enables and status
  output logic [3:0][255:0] o_tap_en,
  output logic o_nv_write_busy_flag
);
  if (NV_WRITE_CYCLES < 1) begin : g_chk
    $error("NV_WRITE_CYCLES must be at least one");
  end

  qpsc_link_if lnk ();
  qpsc_nv_if nv ();

  qpsc_serial_rx u_rx (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_sck(i_sck),
    .i_si(i_si),
    .i_cs_n(i_cs_n),
    .i_hold_n(i_hold_n),
    .i_wp_n(i_wp_n),
    .i_addr(i_chip_address_pins),
    .lnk(lnk.rx)
  );

  qpsc_nv_store #(.NV_CYCLES(NV_WRITE_CYCLES)) u_nv (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .nv(nv.store)
  );

  // ==========================================================
  // state
  qpsc_pkg::qpsc_state_t state_q, state_d;
  logic [3:0][7:0] wiper_position_register_q, wiper_d;
  logic [3:0] op_q, op_d;
  logic [1:0] pot_select_bits_q, pot_d;
  logic [1:0] register_select_bits_q, reg_d;
  logic [7:0] out_q, out_d;
  logic [7:0] data_q, data_d;
  logic pend_q, pend_d;
  logic pend_glb_q, pend_glb_d;
  logic so_q, so_d;
  logic oe_q, oe_d;
  logic recall_q;
  logic commit_w;

  // ==========================================================
  // decode of the byte just received
  wire [7:0] rx_byte = lnk.byte_data;
  wire [3:0] rx_hi = qpsc_pkg::hi_of(rx_byte);
  wire [1:0] rx_pot = qpsc_pkg::pot_of(rx_byte);
  wire [1:0] rx_reg = qpsc_pkg::reg_of(rx_byte);
  wire type_ok = rx_hi == qpsc_pkg::TYPE_CODE;
  // middle bits are the host's to keep at zero and are not checked
  wire addr_ok = rx_pot == lnk.addr;
  wire id_ok = type_ok && addr_ok;
  wire in_instr = state_q == qpsc_pkg::ST_INSTR;
  wire [7:0] status_byte = 8'(nv.busy) << qpsc_pkg::STATUS_BUSY_BIT;

  assign nv.rd_pot = in_instr ? rx_pot : pot_select_bits_q;
  assign nv.rd_reg = recall_q ? 2'h0 : (in_instr ? rx_reg : register_select_bits_q);
  assign commit_w = lnk.cs_rise && pend_q && lnk.wp_n;
  assign nv.wr_req = commit_w;
  assign nv.wr_global = pend_glb_q;
  assign nv.wr_pot = pot_select_bits_q;
  assign nv.wr_reg = register_select_bits_q;
  assign nv.wr_data = data_q;
  assign nv.wr_wipers = wiper_position_register_q;

  // ==========================================================
  // command sequencer
  always_comb begin
    state_d = state_q;
    wiper_d = wiper_position_register_q;
    op_d = op_q;
    pot_d = pot_select_bits_q;
    reg_d = register_select_bits_q;
    out_d = out_q;
    data_d = data_q;
    pend_d = pend_q;
    pend_glb_d = pend_glb_q;
    so_d = so_q;
    oe_d = oe_q;
    if (recall_q) wiper_d = nv.rd_col;
    if (lnk.cs_rise) begin
      state_d = qpsc_pkg::ST_ID;
      oe_d = 1'b0;
      pend_d = 1'b0;
    end else begin
      case (state_q)
        qpsc_pkg::ST_ID: begin
          if (lnk.byte_valid) state_d = id_ok ? qpsc_pkg::ST_INSTR : qpsc_pkg::ST_SKIP;
        end
        qpsc_pkg::ST_INSTR: begin
          if (lnk.byte_valid) begin
            op_d = rx_hi;
            pot_d = rx_pot;
            reg_d = rx_reg;
            state_d = qpsc_pkg::ST_DONE;
            case (rx_hi)
              qpsc_pkg::OP_RD_WIPER: begin
                out_d = wiper_position_register_q[rx_pot];
                state_d = qpsc_pkg::ST_READ;
              end
              qpsc_pkg::OP_RD_NV: begin
                out_d = nv.rd_data;
                state_d = qpsc_pkg::ST_READ;
              end
              qpsc_pkg::OP_STATUS: begin
                out_d = status_byte;
                state_d = qpsc_pkg::ST_READ;
              end
              qpsc_pkg::OP_WR_WIPER, qpsc_pkg::OP_WR_NV: state_d = qpsc_pkg::ST_DATA;
              qpsc_pkg::OP_NV_TO_WIPER: wiper_d[rx_pot] = nv.rd_data;
              qpsc_pkg::OP_G_NV_TO_WIPER: wiper_d = nv.rd_col;
              qpsc_pkg::OP_WIPER_TO_NV, qpsc_pkg::OP_G_WIPER_TO_NV: begin
                data_d = wiper_position_register_q[rx_pot];
                pend_d = 1'b1;
                pend_glb_d = rx_hi == qpsc_pkg::OP_G_WIPER_TO_NV;
              end
              qpsc_pkg::OP_STEP: state_d = qpsc_pkg::ST_STEP;
              default: state_d = qpsc_pkg::ST_SKIP;
            endcase
          end
        end
        qpsc_pkg::ST_DATA: begin
          if (lnk.byte_valid) begin
            state_d = qpsc_pkg::ST_DONE;
            if (op_q == qpsc_pkg::OP_WR_WIPER) begin
              wiper_d[pot_select_bits_q] = rx_byte;
            end else begin
              data_d = rx_byte;
              pend_d = 1'b1;
              pend_glb_d = 1'b0;
            end
          end
        end
        qpsc_pkg::ST_READ: begin
          if (lnk.sck_fall) begin
            so_d = out_q[7];
            out_d = {out_q[6:0], 1'b0};
            oe_d = 1'b1;
          end
          if (lnk.byte_valid) begin
            state_d = qpsc_pkg::ST_DONE;
            oe_d = 1'b0;
          end
        end
        qpsc_pkg::ST_STEP: begin
          if (lnk.sck_rise) begin
            wiper_d[pot_select_bits_q] =
              qpsc_pkg::step(wiper_position_register_q[pot_select_bits_q], lnk.si);
          end
        end
        qpsc_pkg::ST_DONE, qpsc_pkg::ST_SKIP: begin
          // extra clocks are ignored until select rises
          state_d = state_q;
        end
        default: state_d = qpsc_pkg::ST_ID;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= qpsc_pkg::ST_ID;
      wiper_position_register_q <= '0;
      op_q <= '0;
      pot_select_bits_q <= '0;
      register_select_bits_q <= '0;
      out_q <= '0;
      data_q <= '0;
      pend_q <= 1'b0;
      pend_glb_q <= 1'b0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wiper_position_register_q <= wiper_d;
      op_q <= op_d;
      pot_select_bits_q <= pot_d;
      register_select_bits_q <= reg_d;
      out_q <= out_d;
      data_q <= data_d;
      pend_q <= pend_d;
      pend_glb_q <= pend_glb_d;
      so_q <= so_d;
      oe_q <= oe_d;
    end
  end

  // one cycle after reset the wipers take data register zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) recall_q <= 1'b1;
    else recall_q <= 1'b0;
  end

  // ==========================================================
  // outputs; tap enables lag the wiper by one cycle, glitch free
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_tap_en <= {4{qpsc_pkg::TAP_RESET}};
      o_nv_write_busy_flag <= 1'b0;
    end else begin
      for (int p = 0; p < qpsc_pkg::N_POTS; p++) begin
        o_tap_en[p] <= qpsc_pkg::onehot(wiper_position_register_q[p]);
      end
      o_nv_write_busy_flag <= nv.busy;
    end
  end
  assign o_so = so_q;
  assign o_so_oe = oe_q;

  // ==========================================================
  // assertions
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_tap_one_hot: assert property ($onehot(o_tap_en[0]) && $onehot(o_tap_en[1]) &&
    $onehot(o_tap_en[2]) && $onehot(o_tap_en[3]))
    else $error("tap enables not one-hot");
  a_tap_follows_wiper: assert property ($stable(wiper_position_register_q[2]) |=>
    o_tap_en[2][$past(wiper_position_register_q[2])])
    else $error("tap enable does not follow wiper");
  a_wp_blocks_save: assert property (!lnk.wp_n && !nv.busy |=> !nv.busy)
    else $error("save started with write-protect low");
  a_save_on_cs_rise: assert property ($rose(nv.busy) |-> $past(lnk.cs_rise && pend_q))
    else $error("save started without select rising after a write");
  a_recall_zero: assert property (recall_q |=> wiper_position_register_q == $past(nv.rd_col))
    else $error("power-up recall missed");
  a_bad_type: assert property (state_q == qpsc_pkg::ST_ID && lnk.byte_valid && !lnk.cs_rise
    && !type_ok |=> state_q == qpsc_pkg::ST_SKIP)
    else $error("wrong type code accepted");
  a_bad_addr: assert property (state_q == qpsc_pkg::ST_ID && lnk.byte_valid && !lnk.cs_rise
    && !addr_ok |=> state_q == qpsc_pkg::ST_SKIP)
    else $error("wrong address accepted");
  a_cs_abort: assert property (lnk.cs_rise |=> state_q == qpsc_pkg::ST_ID && !o_so_oe)
    else $error("select rise did not abort");
  a_step_top: assert property (state_q == qpsc_pkg::ST_STEP && lnk.sck_rise && lnk.si &&
    !lnk.cs_rise && wiper_position_register_q[pot_select_bits_q] == qpsc_pkg::WIPER_MAX
    |=> wiper_position_register_q[pot_select_bits_q] == qpsc_pkg::WIPER_MAX)
    else $error("step wrapped past the top");
  a_so_on_fall: assert property ($changed(o_so) |-> $past(lnk.sck_fall))
    else $error("serial output changed off a falling edge");
  a_wiper_write: assert property (state_q == qpsc_pkg::ST_DATA && lnk.byte_valid &&
    !lnk.cs_rise && op_q == qpsc_pkg::OP_WR_WIPER |=>
    wiper_position_register_q[$past(pot_select_bits_q)] == $past(rx_byte))
    else $error("wiper write lost");
  c_read: cover property (state_q == qpsc_pkg::ST_READ && lnk.byte_valid);
  c_step: cover property (state_q == qpsc_pkg::ST_STEP && lnk.sck_rise);
  c_commit: cover property (commit_w);
  c_skip: cover property (state_q == qpsc_pkg::ST_SKIP);
endmodule : qpsc_top

// ==== tb/qpsc_host_model.sv ====
module qpsc_host_model (
  // clock
  input wire logic i_sys_clk,
  // serial pins
  output logic o_sck,
  output logic o_si,
  output logic o_cs_n,
  output logic o_hold_n,
  input wire logic i_so,
  input wire logic i_so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sck = 1'b0;
    o_si = 1'b0;
    o_cs_n = 1'b1;
    o_hold_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : wait_clk
  // select is only lowered with sck low, so every frame opens with a real fall
  task automatic sel();
    wait_clk(4);
    o_cs_n = 1'b0;
    wait_clk(4);
  endtask : sel
  task automatic desel();
    wait_clk(4);
    o_cs_n = 1'b1;
    // a released data line must not keep its last level
    o_si = ~o_si;
    wait_clk(4);
  endtask : desel
  // mode 0, msb first; low phase 5 clocks so the synced so bit has landed
  task automatic xfer(input logic [7:0] tx, input int nbits, input bit pause,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      o_si = tx[i];
      if (pause && i == 3) begin
        o_hold_n = 1'b0;
        wait_clk(3);
        o_sck = 1'b1;
        o_si = ~o_si;
        wait_clk(4);
        o_sck = 1'b0;
        o_si = tx[i];
        wait_clk(3);
        o_hold_n = 1'b1;
      end
      wait_clk(5);
      rx[i] = i_so_oe ? i_so : 1'bz;
      o_sck = 1'b1;
      wait_clk(3);
      o_sck = 1'b0;
    end
  endtask : xfer
endmodule : qpsc_host_model

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NV_CYC = 400;
  localparam logic [7:0] ID_OK = {qpsc_pkg::TYPE_CODE, 4'b0010};
  logic clk, rst_n, sck, si, cs_n, hold_n, so, so_oe, wp_n, busy;
  logic [1:0] addr;
  logic [3:0][255:0] tap_en;
  logic [7:0] rx;
  int fails = 0;
  int samples_checked = 0;
  assign addr = 2'b10;
  qpsc_top #(.NV_WRITE_CYCLES(NV_CYC)) dut_u (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_sck(sck), .i_si(si), .i_cs_n(cs_n), .i_hold_n(hold_n), .o_so(so), .o_so_oe(so_oe),
    .i_wp_n(wp_n), .i_chip_address_pins(addr), .o_tap_en(tap_en), .o_nv_write_busy_flag(busy));
  qpsc_host_model host_u (.i_sys_clk(clk), .o_sck(sck), .o_si(si), .o_cs_n(cs_n),
    .o_hold_n(hold_n), .i_so(so), .i_so_oe(so_oe));
  // ==========================================================
  // helpers
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] id, instr, data, input int nbits, input bit pause);
    logic [7:0] r;
    host_u.sel();
    host_u.xfer(id, 8, 1'b0, r);
    host_u.xfer(instr, 8, 1'b0, r);
    if (nbits > 0) host_u.xfer(data, nbits, pause, rx);
    host_u.desel();
  endtask : cmd
  task automatic stop_test();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // ==========================================================
  // scenarios
  task automatic t_wiper();
    for (int p = 0; p < 4; p++) begin
      cmd(ID_OK, {qpsc_pkg::OP_WR_WIPER, 2'b00, 2'(p)}, 8'(15 + p * 75), 8, p == 2);
      check(tap_en[p], 256'h1 << (15 + p * 75));
    end
    for (int p = 0; p < 4; p++) begin
      cmd(ID_OK, {qpsc_pkg::OP_RD_WIPER, 2'b00, 2'(p)}, 8'h00, 8, 1'b0);
      check({248'h0, rx}, 256'(15 + p * 75));
      check({255'h0, so_oe}, 256'h0);
    end
    cmd({~qpsc_pkg::TYPE_CODE, 4'b0010}, {qpsc_pkg::OP_WR_WIPER, 4'h0}, 8'h77, 8, 1'b0);
    check(tap_en[0], 256'h1 << 15);
    cmd({qpsc_pkg::TYPE_CODE, 4'b0001}, {qpsc_pkg::OP_WR_WIPER, 4'h0}, 8'h77, 8, 1'b0);
    check(tap_en[0], 256'h1 << 15);
  endtask : t_wiper
  task automatic t_nv();
    wp_n = 1'b0;
    cmd(ID_OK, {qpsc_pkg::OP_WR_NV, 4'b0100}, 8'h5a, 8, 1'b0);
    check({255'h0, busy}, 256'h0);
    wp_n = 1'b1;
    cmd(ID_OK, {qpsc_pkg::OP_WR_NV, 4'b1000}, 8'h33, 5, 1'b0);
    check({255'h0, busy}, 256'h0);
    cmd(ID_OK, {qpsc_pkg::OP_WR_NV, 4'b0100}, 8'h5a, 8, 1'b0);
    host_u.wait_clk(2);
    check({255'h0, busy}, 256'h1);
    cmd(ID_OK, {qpsc_pkg::OP_STATUS, 4'h0}, 8'h00, 8, 1'b0);
    check({248'h0, rx}, 256'h1);
    for (int i = 0; i < NV_CYC && busy !== 1'b0; i++) @(posedge clk);
    #1;
    check({255'h0, busy}, 256'h0);
    for (int r = 0; r < 3; r++) begin
      cmd(ID_OK, {qpsc_pkg::OP_RD_NV, 2'(r), 2'b00}, 8'h00, 8, 1'b0);
      check({248'h0, rx}, (r == 1) ? 256'h5a : 256'h0);
    end
  endtask : t_nv
  task automatic t_xfer();
    cmd(ID_OK, {qpsc_pkg::OP_G_NV_TO_WIPER, 4'b0100}, 8'h00, 0, 1'b0);
    check(tap_en[0], 256'h1 << 8'h5a);
    check(tap_en[3], 256'h1);
    cmd(ID_OK, {qpsc_pkg::OP_WR_WIPER, 4'h0}, 8'h11, 8, 1'b0);
    cmd(ID_OK, {qpsc_pkg::OP_NV_TO_WIPER, 4'b0100}, 8'h00, 0, 1'b0);
    check(tap_en[0], 256'h1 << 8'h5a);
    // wiper to data register, single and global, each saved at select rise
    cmd(ID_OK, {qpsc_pkg::OP_WR_WIPER, 4'h0}, 8'h3c, 8, 1'b0);
    cmd(ID_OK, {qpsc_pkg::OP_WIPER_TO_NV, 4'b1000}, 8'h00, 0, 1'b0);
    for (int i = 0; i < NV_CYC + 8 && busy !== 1'b0; i++) @(posedge clk);
    #1;
    cmd(ID_OK, {qpsc_pkg::OP_RD_NV, 4'b1000}, 8'h00, 8, 1'b0);
    check({248'h0, rx}, 256'h3c);
    cmd(ID_OK, {qpsc_pkg::OP_G_WIPER_TO_NV, 4'b1100}, 8'h00, 0, 1'b0);
    for (int i = 0; i < NV_CYC + 8 && busy !== 1'b0; i++) @(posedge clk);
    #1;
    cmd(ID_OK, {qpsc_pkg::OP_RD_NV, 4'b1100}, 8'h00, 8, 1'b0);
    check({248'h0, rx}, 256'h3c);
    cmd(ID_OK, {qpsc_pkg::OP_RD_NV, 4'b1101}, 8'h00, 8, 1'b0);
    check({248'h0, rx}, 256'h0);
  endtask : t_xfer
  task automatic t_step();
    logic [7:0] tbl [3][3] = '{'{8'hfd, 8'hff, 8'hff}, '{8'h03, 8'h00, 8'h00},
                                '{8'h80, 8'hb0, 8'h7e}};
    for (int k = 0; k < 3; k++) begin
      cmd(ID_OK, {qpsc_pkg::OP_WR_WIPER, 4'b0001}, tbl[k][0], 8, 1'b0);
      cmd(ID_OK, {qpsc_pkg::OP_STEP, 4'b0001}, tbl[k][1], 8, 1'b0);
      check(tap_en[1], 256'h1 << tbl[k][2]);
    end
  endtask : t_step
  // ==========================================================
  // run
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2_000_000;
    fails++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    host_u.wait_clk(4);
    for (int p = 0; p < 4; p++) check(tap_en[p], 256'h1);
    t_wiper();
    t_nv();
    t_xfer();
    t_step();
    stop_test();
  end
endmodule : tb_top
